// ==== hdl/fhec_bus_cycle.sv ====
// one asynchronous flash bus cycle (read or write) with timed strobes
// assumes rst_n is already synchronised; flash data pins are asynchronous
`timescale 1ns/1ps
`include "fhec_cfg.svh"
module fhec_bus_cycle
    import fhec_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // request side
    input  wire logic        start,
    input  wire logic        write,
    input  wire logic [25:0] addr,
    input  wire logic [15:0] wdata,
    output logic             done,
    output logic [15:0]      rdata,
    // flash pins
    output logic [25:0]      flash_addr,
    output logic [15:0]      flash_dq_out,
    output logic             flash_dq_oe,
    input  wire logic [15:0] flash_dq_in,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n
);

    localparam logic [4:0] RD_CYC = 5'(`FHEC_RD_CYC);
    localparam logic [4:0] WR_CYC = 5'(`FHEC_WR_CYC);
    localparam logic [4:0] SU_CYC = 5'(`FHEC_SU_CYC);

    fhec_bus_t   st_q;
    logic [4:0]  cnt_q;
    logic        wr_q;
    logic [15:0] dq_s1_q;
    logic [15:0] dq_s2_q;

    wire         cnt_end = (cnt_q == 5'h01);

    // data pins pass two flops; read pulse is long enough to cover the sync delay
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
        end else begin
            dq_s1_q <= flash_dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end

    // strobe sequencer: setup, pulse, hold; one cycle of hold separates cycles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= FHEC_BUS_IDLE;
            cnt_q <= 5'h00;
            wr_q  <= 1'b0;
        end else begin
            case (st_q)
                FHEC_BUS_IDLE: begin
                    if (start) begin
                        st_q  <= FHEC_BUS_SETUP;
                        cnt_q <= SU_CYC;
                        wr_q  <= write;
                    end
                end
                FHEC_BUS_SETUP: begin
                    cnt_q <= cnt_q - 5'h01;
                    if (cnt_end) begin
                        st_q  <= FHEC_BUS_PULSE;
                        cnt_q <= wr_q ? WR_CYC : RD_CYC;
                    end
                end
                FHEC_BUS_PULSE: begin
                    cnt_q <= cnt_q - 5'h01;
                    if (cnt_end) begin
                        st_q <= FHEC_BUS_HOLD;
                    end
                end
                default: begin
                    st_q <= FHEC_BUS_IDLE;
                end
            endcase
        end
    end

    // pin drivers, address and write data are held for the whole cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flash_addr   <= 26'h0000000;
            flash_dq_out <= 16'h0000;
            flash_dq_oe  <= 1'b0;
            flash_ce_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
            flash_we_n   <= 1'b1;
            rdata        <= 16'h0000;
            done         <= 1'b0;
        end else begin
            done <= (st_q == FHEC_BUS_HOLD);
            if (st_q == FHEC_BUS_IDLE && start) begin
                flash_addr   <= addr;
                flash_dq_out <= wdata;
                flash_dq_oe  <= write;
                flash_ce_n   <= 1'b0;
            end
            if (st_q == FHEC_BUS_SETUP && cnt_end) begin
                flash_oe_n <= wr_q;
                flash_we_n <= !wr_q;
            end
            if (st_q == FHEC_BUS_PULSE && cnt_end) begin
                flash_oe_n <= 1'b1;
                flash_we_n <= 1'b1;
                if (!wr_q) begin
                    rdata <= dq_s2_q;
                end
            end
            if (st_q == FHEC_BUS_HOLD) begin
                flash_ce_n  <= 1'b1;
                flash_dq_oe <= 1'b0;
            end
        end
    end

endmodule

// ==== hdl/fhec_cfg.svh ====
// constants of the flash error-status host controller: offsets, fields,
// flash command codes and bus-cycle timing counts
// assumes a 100 MHz system clock and a x16 parallel flash
`ifndef FHEC_CFG_SVH
`define FHEC_CFG_SVH

// register offsets on the software port (byte addresses)
`define FHEC_OFS_CTRL       8'h00
`define FHEC_OFS_STAT       8'h04
`define FHEC_OFS_CMD        8'h08
`define FHEC_OFS_ADDR       8'h0c

// control fields
`define FHEC_CTRL_AUTO      0
`define FHEC_CTRL_USE_CLR   1
`define FHEC_CMD_CHECK      0
`define FHEC_CTRL_RST       2'h0

// embedded status fields
`define FHEC_SR_VALID       7
`define FHEC_SR_ERASE_ERR   5
`define FHEC_SR_PROG_ERR    4
`define FHEC_SR_ABORT       3
`define FHEC_SR_PROTECT     1

// polling bits
`define FHEC_POLL_TOGGLE    6
`define FHEC_POLL_TIMEOUT   5
`define FHEC_POLL_ABORT     1

// flash command words and command addresses
`define FHEC_FCMD_SR_READ   16'h0070
`define FHEC_FCMD_SR_CLEAR  16'h0071
`define FHEC_FCMD_RESET     16'h00f0
`define FHEC_FCMD_UNLOCK1   16'h00aa
`define FHEC_FCMD_UNLOCK2   16'h0055
`define FHEC_FADDR_UNLOCK1  26'h0000555
`define FHEC_FADDR_UNLOCK2  26'h00002aa

// timing: system clock, strobe widths, protection busy limit
`define FHEC_CLK_MHZ        100
`define FHEC_T_RD_PULSE_NS  120
`define FHEC_T_WR_PULSE_NS  40
`define FHEC_T_SETUP_NS     10
`define FHEC_T_PROT_MAX_US  100
`define FHEC_RD_CYC  ((`FHEC_T_RD_PULSE_NS * `FHEC_CLK_MHZ + 999) / 1000)
`define FHEC_WR_CYC  ((`FHEC_T_WR_PULSE_NS * `FHEC_CLK_MHZ + 999) / 1000)
`define FHEC_SU_CYC  ((`FHEC_T_SETUP_NS * `FHEC_CLK_MHZ + 999) / 1000)
`define FHEC_PROT_CYC (`FHEC_T_PROT_MAX_US * `FHEC_CLK_MHZ)

`endif

// ==== hdl/fhec_host_ctrl.sv ====
// host controller that detects and clears embedded-algorithm errors of a
// parallel NOR flash through its pins, under orders from a register port
// assumes one 100 MHz clock; flash pins and ready/busy are asynchronous
//
// Overview of operation
// [R1] a failed operation keeps the flash busy with valid status shown
// [R2] flash stays in error until this host detects and clears it
// [R3] polling bit 7 inverts last buffer word, zero after erase failure
// [R4] op failure: timeout bit 1, erase-started 1, abort bit 0, toggles run
// [R5] op failure status: bit7 set, bit5 erase, bit4 program, bits3-1 zero
// [R6] op failure is cleared by reset or status-clear command
// [R7] during op failure only status read, reset and status-clear are taken
// [R8] protection error keeps flash busy 20 to 100 us, then self-recovers
// [R9] protection busy: ready/busy low, status shows not ready, bit7 zero
// [R10] protection busy polling: timeout 0, erase-started 1, abort 0
// [R11] protection busy: only status read command is accepted
// [R12] after protection busy ends any command is accepted again
// [R13] after protection error status shows bit7, bit1 and bit5 or bit4
// [R14] invalid buffer-load values abort before programming, flash stays busy
// [R15] buffer abort polling: abort bit 1, timeout bit 0, toggle runs
// [R16] buffer abort during erase suspend sets erase-started bit
// [R17] buffer abort status: bit7, bit4, bit3 set; bits 5,2,1 clear
// [R18] buffer abort cleared by abort-reset or status-clear only
// [R19] host masks polling bits 4,0 and status bits 0 and 6
// [R20] after clearing flash returns to its prior state
// [R21] commands outside the accepted list are ignored by the flash
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "fhec_cfg.svh"
module fhec_host_ctrl
    import fhec_pkg::*;
#(
    parameter int unsigned WAIT_CYC = `FHEC_PROT_CYC
)(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // software register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // flash pins
    output logic [25:0]      flash_addr,
    output logic [15:0]      flash_dq_out,
    output logic             flash_dq_oe,
    input  wire logic [15:0] flash_dq_in,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    input  wire logic        flash_ready_busy
);

    logic [1:0]  rst_sync_q;
    logic [1:0]  rb_sync_q;
    fhec_state_t st_q;
    fhec_err_t   err_q;
    logic [1:0]  ctrl_q;
    logic [25:0] poll_addr_q;
    logic [15:0] poll_a_q;
    logic [15:0] poll_b_q;
    logic [7:0]  sr_q;
    logic        pend_q;
    logic [1:0]  clr_step_q;
    logic [31:0] wait_q;
    logic [15:0] bus_rdata;
    logic        bus_done;

    // reset release through two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    wire rst_q_n = rst_sync_q[1];

    // ready/busy pin through two flops
    always_ff @(posedge clock or negedge rst_q_n) begin
        if (!rst_q_n) begin
            rb_sync_q <= 2'b00;
        end else begin
            rb_sync_q <= {rb_sync_q[0], flash_ready_busy};
        end
    end
    wire rb_ready = rb_sync_q[1];

    // register decode
    wire wr_ctrl  = reg_wr && (reg_addr == `FHEC_OFS_CTRL);
    wire wr_cmd   = reg_wr && (reg_addr == `FHEC_OFS_CMD);
    wire wr_addr  = reg_wr && (reg_addr == `FHEC_OFS_ADDR);
    wire check_go = wr_cmd && reg_wdata[`FHEC_CMD_CHECK] && (st_q == FHEC_IDLE);
    wire auto_clr = ctrl_q[`FHEC_CTRL_AUTO];
    wire use_clr  = ctrl_q[`FHEC_CTRL_USE_CLR];

    // [R19] status bits 6 and 0 are masked before any decision
    wire [7:0] sr_m = sr_q & 8'hbe;
    // [R4] toggle seen when two polling reads differ in bit 6
    wire toggling = poll_a_q[`FHEC_POLL_TOGGLE] ^ poll_b_q[`FHEC_POLL_TOGGLE];

    // [R5] [R13] [R17] classify the error from the masked status
    wire sr_valid = sr_m[`FHEC_SR_VALID];
    wire is_prot  = sr_valid && sr_m[`FHEC_SR_PROTECT];
    wire is_abort = sr_valid && sr_m[`FHEC_SR_ABORT] && sr_m[`FHEC_SR_PROG_ERR];
    wire is_fail  = sr_valid && (sr_m[`FHEC_SR_ERASE_ERR] || sr_m[`FHEC_SR_PROG_ERR])
                    && !is_prot && !is_abort;
    // [R9] not ready status while busy: protection busy or a running algorithm
    wire is_pend  = !sr_valid && !rb_ready;
    fhec_err_t err_d;
    assign err_d = is_prot  ? FHEC_ERR_PROTECT :
                   is_abort ? FHEC_ERR_ABORT :
                   is_fail  ? FHEC_ERR_OPFAIL :
                   is_pend  ? FHEC_ERR_PENDING : FHEC_ERR_NONE;
    // [R2] [R6] [R18] only stuck errors are cleared, and only when allowed
    wire need_clr = auto_clr && (is_fail || is_abort);

    // [R6] [R7] [R18] [R21] clearing words: status-clear, reset, or abort-reset
    wire       seq3 = (err_q == FHEC_ERR_ABORT) && !use_clr;
    wire [1:0] clr_last = seq3 ? 2'h2 : 2'h0;
    wire [15:0] clr_word = use_clr ? `FHEC_FCMD_SR_CLEAR :
                           !seq3 ? `FHEC_FCMD_RESET :
                           (clr_step_q == 2'h0) ? `FHEC_FCMD_UNLOCK1 :
                           (clr_step_q == 2'h1) ? `FHEC_FCMD_UNLOCK2 : `FHEC_FCMD_RESET;
    wire [25:0] clr_adr  = (seq3 && clr_step_q == 2'h1) ? `FHEC_FADDR_UNLOCK2
                                                          : `FHEC_FADDR_UNLOCK1;

    // bus request selection by state
    wire in_bus = (st_q == FHEC_POLL_A) || (st_q == FHEC_POLL_B) ||
                  (st_q == FHEC_SR_CMD) || (st_q == FHEC_SR_RD) || (st_q == FHEC_CLEAR);
    wire bus_go = in_bus && !pend_q;
    // [R7] [R11] the status read command is accepted in every error state
    wire bus_wr = (st_q == FHEC_SR_CMD) || (st_q == FHEC_CLEAR);
    wire [25:0] bus_adr = (st_q == FHEC_SR_CMD) ? `FHEC_FADDR_UNLOCK1 :
                          (st_q == FHEC_CLEAR) ? clr_adr : poll_addr_q;
    wire [15:0] bus_wd  = (st_q == FHEC_CLEAR) ? clr_word : `FHEC_FCMD_SR_READ;
    wire wait_end = (wait_q == 32'h00000000);

    // software-written control and address
    always_ff @(posedge clock or negedge rst_q_n) begin
        if (!rst_q_n) begin
            ctrl_q      <= `FHEC_CTRL_RST;
            poll_addr_q <= 26'h0000000;
        end else begin
            if (wr_ctrl) ctrl_q <= reg_wdata[1:0];
            if (wr_addr) poll_addr_q <= reg_wdata[25:0];
        end
    end

    // read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock or negedge rst_q_n) begin
        if (!rst_q_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `FHEC_OFS_CTRL: reg_rdata <= {30'h00000000, ctrl_q};
                `FHEC_OFS_STAT: reg_rdata <= {poll_b_q, sr_q, 1'b0, toggling, 1'b0,
                                              err_q, rb_ready, (st_q != FHEC_IDLE)};
                `FHEC_OFS_ADDR: reg_rdata <= {6'h00, poll_addr_q};
                default:        reg_rdata <= 32'h00000000;
            endcase
        end
    end

    // bus request bookkeeping and captured words
    always_ff @(posedge clock or negedge rst_q_n) begin
        if (!rst_q_n) begin
            pend_q   <= 1'b0;
            poll_a_q <= 16'h0000;
            poll_b_q <= 16'h0000;
            sr_q     <= 8'h00;
        end else begin
            if (bus_go) pend_q <= 1'b1;
            else if (bus_done) pend_q <= 1'b0;
            if (bus_done && st_q == FHEC_POLL_A) poll_a_q <= bus_rdata;
            if (bus_done && st_q == FHEC_POLL_B) poll_b_q <= bus_rdata;
            if (bus_done && st_q == FHEC_SR_RD) sr_q <= bus_rdata[7:0];
        end
    end

    // sequence: two polls, status read, decide, clear, wait for ready
    always_ff @(posedge clock or negedge rst_q_n) begin
        if (!rst_q_n) begin
            st_q       <= FHEC_IDLE;
            err_q      <= FHEC_ERR_NONE;
            clr_step_q <= 2'h0;
            wait_q     <= 32'h00000000;
        end else begin
            case (st_q)
                FHEC_IDLE: if (check_go) st_q <= FHEC_POLL_A;
                FHEC_POLL_A: if (bus_done) st_q <= FHEC_POLL_B;
                FHEC_POLL_B: if (bus_done) st_q <= FHEC_SR_CMD;
                FHEC_SR_CMD: if (bus_done) st_q <= FHEC_SR_RD;
                FHEC_SR_RD: if (bus_done) st_q <= FHEC_DECIDE;
                FHEC_DECIDE: begin
                    err_q      <= err_d;
                    clr_step_q <= 2'h0;
                    wait_q     <= WAIT_CYC;
                    // [R8] [R12] protection busy ends by itself; just wait it out
                    if (need_clr) st_q <= FHEC_CLEAR;
                    else if (is_pend) st_q <= FHEC_WAIT;
                    else st_q <= FHEC_IDLE;
                end
                FHEC_CLEAR: begin
                    if (bus_done) begin
                        clr_step_q <= clr_step_q + 2'h1;
                        if (clr_step_q == clr_last) st_q <= FHEC_WAIT;
                    end
                end
                FHEC_WAIT: begin
                    // [R20] ready/busy high means the flash is back in its prior state
                    wait_q <= wait_q - 32'h00000001;
                    if (rb_ready) begin
                        st_q <= FHEC_IDLE;
                        if (err_q == FHEC_ERR_PENDING) err_q <= FHEC_ERR_NONE;
                    end else if (wait_end) begin
                        st_q  <= FHEC_IDLE;
                        err_q <= FHEC_ERR_TIMEOUT;
                    end
                end
                default: st_q <= FHEC_IDLE;
            endcase
        end
    end

    // flash bus cycle engine
    fhec_bus_cycle u_bus (
        .clock        (clock),
        .rst_n        (rst_q_n),
        .start        (bus_go),
        .write        (bus_wr),
        .addr         (bus_adr),
        .wdata        (bus_wd),
        .done         (bus_done),
        .rdata        (bus_rdata),
        .flash_addr   (flash_addr),
        .flash_dq_out (flash_dq_out),
        .flash_dq_oe  (flash_dq_oe),
        .flash_dq_in  (flash_dq_in),
        .flash_ce_n   (flash_ce_n),
        .flash_oe_n   (flash_oe_n),
        .flash_we_n   (flash_we_n)
    );

endmodule

// ==== hdl/fhec_pkg.sv ====
// types shared by the flash error-status host controller
package fhec_pkg;

    typedef enum logic [3:0] {
        FHEC_IDLE   = 4'b0000,
        FHEC_POLL_A = 4'b0001,
        FHEC_POLL_B = 4'b0010,
        FHEC_SR_CMD = 4'b0011,
        FHEC_SR_RD  = 4'b0100,
        FHEC_DECIDE = 4'b0101,
        FHEC_CLEAR  = 4'b0110,
        FHEC_WAIT   = 4'b0111
    } fhec_state_t;

    typedef enum logic [2:0] {
        FHEC_ERR_NONE    = 3'b000,
        FHEC_ERR_OPFAIL  = 3'b001,
        FHEC_ERR_PROTECT = 3'b010,
        FHEC_ERR_ABORT   = 3'b011,
        FHEC_ERR_PENDING = 3'b100,
        FHEC_ERR_TIMEOUT = 3'b101
    } fhec_err_t;

    typedef enum logic [1:0] {
        FHEC_BUS_IDLE  = 2'b00,
        FHEC_BUS_SETUP = 2'b01,
        FHEC_BUS_PULSE = 2'b10,
        FHEC_BUS_HOLD  = 2'b11
    } fhec_bus_t;

endpackage

// ==== sim/fhec_flash_model.sv ====
// behavioural flash: error kinds, polling overlay, status byte, command filter
// assumes the host drives the strobes; the bench injects errors with inject()
`timescale 1ns/1ps
module fhec_flash_model #(
    parameter int PROT_NS = 800
)(
    // pins from the host
    input  wire logic [25:0] flash_addr,
    input  wire logic [15:0] flash_dq_out,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_we_n,
    // pins to the host
    output logic [15:0]      flash_dq_in,
    output logic             flash_ready_busy
);
    int          kind_q = 0;       // 0 none, 1 op failure, 2 protection, 3 buffer abort
    logic        erase_q = 1'b0;   // erase failure, or erase suspended under an abort
    logic        d7_q = 1'b0;      // bit 7 of the last buffer word
    logic        sr_next_q = 1'b0;
    logic        tog_q = 1'b0;
    logic [1:0]  unlock_q = 2'h0;
    logic [7:0]  sr_q = 8'h80;
    logic [15:0] word;
    initial flash_dq_in = 16'hffff;
    assign flash_ready_busy = (kind_q == 0);
    task automatic inject(input int k, input logic erase, input logic d7);
        kind_q = k;
        erase_q = erase;
        d7_q = d7;
        sr_q = (k == 1) ? (erase ? 8'ha0 : 8'h90) : (k == 3) ? 8'h98 : 8'h00;
        if (k == 2) begin
            fork
                begin
                    #(PROT_NS);
                    sr_q = erase_q ? 8'ha2 : 8'h92;
                    kind_q = 0;
                end
            join_none
        end
    endtask
    // overlay on every address, toggles per read
    always @(negedge flash_oe_n) begin
        if (!flash_ce_n) begin
            tog_q = ~tog_q;
            word = {8'h00, (erase_q && kind_q != 3) ? 1'b0 : ~d7_q, tog_q, kind_q == 1,
                    1'b1, kind_q != 3 || erase_q, tog_q, kind_q == 3, ~tog_q};
            if (sr_next_q) flash_dq_in = {8'h00, sr_q};
            else if (kind_q != 0) flash_dq_in = word;
            else flash_dq_in = flash_addr[15:0];
            sr_next_q = 1'b0;
        end
    end
    // released bus: no stale value survives
    always @(posedge flash_oe_n) flash_dq_in = ~flash_dq_in;
    always @(posedge flash_we_n) begin
        if (!flash_ce_n) begin
            if (flash_dq_out == 16'h0070) sr_next_q = 1'b1;
            else if (kind_q != 2 && (flash_dq_out == 16'h0071 || (flash_dq_out == 16'h00f0
                     && (kind_q != 3 || unlock_q == 2'h2)))) begin
                kind_q = 0;
                sr_q = 8'h80;
            end
            unlock_q = (flash_dq_out == 16'h00aa && flash_addr[11:0] == 12'h555) ? 2'h1 :
                (flash_dq_out == 16'h0055 && unlock_q == 2'h1) ? 2'h2 : 2'h0;
        end
    end
endmodule

// ==== sim/fhec_host_ctrl_sva.sv ====
// checker for the flash error host: strobe timing, commands, register port
// assumes it is bound to fhec_host_ctrl and sees only its ports
`timescale 1ns/1ps
module fhec_host_ctrl_sva #(
    parameter int unsigned WAIT_CYC = 50
)(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // flash pins
    input wire logic [25:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic        flash_dq_oe,
    input wire logic        flash_ce_n,
    input wire logic        flash_oe_n,
    input wire logic        flash_we_n
);
    logic [4:0] oe_low_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // read strobe length; a counter since 12 is beyond a short repetition
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) oe_low_q <= 5'h00;
        else oe_low_q <= flash_oe_n ? 5'h00 : oe_low_q + 5'h01;
    end
    // write pulse, then chip deselect one cycle later
    sequence s_we_pulse;
        !flash_we_n [*4] ##1 flash_we_n ##1 $rose(flash_ce_n);
    endsequence
    sequence s_ctrl_wr_rd;
        reg_wr && reg_addr == 8'h00 ##1 reg_rd && reg_addr == 8'h00;
    endsequence
    a_we_width: assert property ($fell(flash_we_n) |-> s_we_pulse)
        else $error("write strobe width wrong");
    a_oe_width: assert property ($rose(flash_oe_n) |-> oe_low_q == 5'h0c)
        else $error("read strobe width wrong");
    a_strobe_sel: assert property (!flash_we_n || !flash_oe_n |-> !flash_ce_n)
        else $error("strobe without chip select");
    a_no_contend: assert property (flash_dq_oe |-> flash_oe_n)
        else $error("data driven during a read");
    a_addr_held: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
        else $error("address moved inside a bus cycle");
    a_data_held: assert property (!flash_we_n && !$past(flash_we_n) |->
        flash_dq_oe && $stable(flash_dq_out))
        else $error("write data moved under the strobe");
    a_cmd_legal: assert property ($fell(flash_we_n) |-> flash_dq_out inside
        {16'h0070, 16'h0071, 16'h00f0, 16'h00aa, 16'h0055})
        else $error("command outside the accepted list");
    a_sr_addr: assert property ($fell(flash_we_n) && flash_dq_out == 16'h0070 |->
        flash_addr == 26'h0000555)
        else $error("status read command at wrong address");
    a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h00, 8'h04, 8'h0c})
        |=> reg_rdata == 32'h0)
        else $error("unreadable address gave data");
    a_ctrl_back: assert property (s_ctrl_wr_rd |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 2))
        else $error("control readback wrong");
    a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule
bind fhec_host_ctrl fhec_host_ctrl_sva #(.WAIT_CYC(WAIT_CYC)) fhec_host_ctrl_sva_i (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

// ==== sim/testbench.sv ====
// self-checking bench for the flash error host controller
// assumes the behavioural flash model on the pins and a 100 MHz clock
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value at %0t: %s", $time, msg); end end
module testbench
    import fhec_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [25:0] flash_addr;
    logic [15:0] flash_dq_out, flash_dq_in;
    logic        flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_ready_busy;
    int          n_fail = 0, tests_run = 0;
    always #5 clock = ~clock;
    // short busy limit keeps the run brief
    fhec_host_ctrl #(.WAIT_CYC(50)) fhec_host_ctrl_i (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_ready_busy(flash_ready_busy));
    fhec_flash_model #(.PROT_NS(800)) fhec_flash_model_i (.flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .flash_dq_in(flash_dq_in), .flash_ready_busy(flash_ready_busy));
    // register port: one-cycle strobes, read data only in the next cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clock);
    endtask
    // one detect-and-clear pass, bounded wait on the busy bit
    task automatic check(input logic [1:0] ctrl, output logic [31:0] st);
        int i;
        wr(8'h00, {30'h0, ctrl});
        @(posedge clock);
        wr(8'h08, 32'h1);
        for (i = 0; i < 200; i++) begin
            rd(8'h04, st);
            if (st[0] === 1'b0) break;
        end
    endtask
    task automatic t_regs();
        logic [31:0] d;
        rd(8'h00, d);
        `CHK(d, 32'h0, "control reset value")
        wr(8'h00, 32'h3);
        rd(8'h00, d);
        `CHK(d[1:0], 2'h3, "control readback")
        wr(8'h10, 32'hffffffff);
        rd(8'h10, d);
        `CHK(d, 32'h0, "unmapped read")
        rd(8'h08, d);
        `CHK(d, 32'h0, "command reads zero")
    endtask
    task automatic t_idle();
        logic [31:0] st;
        check(2'h1, st);
        `CHK(st[4:2], FHEC_ERR_NONE, "idle flash flagged")
        `CHK(st[1], 1'b1, "idle ready level")
    endtask
    // inject an error, let the host detect and clear it
    task automatic t_err(input int k, input logic er, input logic uc, input logic [7:0] sr,
                         input logic [2:0] ek, input logic [15:0] m, input logic [15:0] poll);
        logic [31:0] st;
        fhec_flash_model_i.inject(k, er, 1'b0);
        check({uc, 1'b1}, st);
        `CHK(st[4:2], ek, "error kind")
        `CHK(st[15:8] & 8'hbe, sr, "status byte")
        `CHK(st[31:16] & m, poll, "polling word")
        `CHK(st[6], 1'b1, "toggle not seen")
        `CHK(flash_ready_busy, 1'b1, "flash left in error")
    endtask
    task automatic t_timeout();
        logic [31:0] st;
        fhec_flash_model_i.inject(1, 1'b0, 1'b0);
        fork
            check(2'h1, st);
            begin
                repeat (2) @(posedge flash_we_n);
                #1 fhec_flash_model_i.inject(1, 1'b0, 1'b0); // the clear does not stick
            end
        join
        `CHK(st[4:2], FHEC_ERR_TIMEOUT, "busy after clear")
        `CHK(flash_ready_busy, 1'b0, "error cleared itself")
        check(2'h1, st);
        `CHK(st[4:2], FHEC_ERR_OPFAIL, "late clear kind")
        `CHK(flash_ready_busy, 1'b1, "late clear failed")
    endtask
    task automatic t_protect();
        logic [31:0] st;
        fhec_flash_model_i.inject(2, 1'b0, 1'b0);
        check(2'h3, st);
        `CHK(st[4:2], FHEC_ERR_NONE, "pending not resolved")
        `CHK(st[15], 1'b0, "status valid while busy")
        `CHK(st[31:16] & 16'h00aa, 16'h0088, "protection polling")
        `CHK(st[1], 1'b1, "protection busy ended")
        check(2'h3, st);
        `CHK(st[4:2], FHEC_ERR_PROTECT, "protection kind")
        `CHK(st[15:8] & 8'hbe, 8'h92, "protection status")
    endtask
    task automatic summarize();
        if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_regs();
        t_idle();
        t_err(1, 1'b0, 1'b0, 8'h90, FHEC_ERR_OPFAIL, 16'h00aa, 16'h00a8);
        t_err(1, 1'b1, 1'b1, 8'ha0, FHEC_ERR_OPFAIL, 16'h00aa, 16'h0028);
        t_err(3, 1'b0, 1'b0, 8'h98, FHEC_ERR_ABORT, 16'h00a2, 16'h0082);
        t_err(3, 1'b1, 1'b1, 8'h98, FHEC_ERR_ABORT, 16'h00aa, 16'h008a);
        t_timeout();
        t_protect();
        summarize();
    end
    // watchdog: nine passes need far less than this
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
endmodule
